// ### drs_pkg.sv
// Constants for the DMA request source selection block
package drs_pkg;
    localparam int NUM_CHANNELS = 4;
    localparam int NUM_SOURCES = 7;
    localparam int SEL_WIDTH = 3;
    localparam int SEL_MSB = 26;
    localparam int SEL_LSB = 24;
    localparam logic [2:0] SEL_UNASSIGNED = 3'h7;
    localparam logic SYNC_RESET_LEVEL = 1'h1;
    localparam logic REQ_RESET_VALUE = 1'h0;
    localparam logic ASSIGNED_RESET_VALUE = 1'h0;
endpackage

// ### drs_source_mux.sv
// One channel's seven-way request source multiplexer
`timescale 1ns/1ns
module drs_source_mux (
    // Selection
    input wire logic [2:0] sel,
    input wire logic hw_mode,
    // Candidate request lines, index equals selector value
    input wire logic [6:0] sources,
    // Routed request
    output logic req
);
    // Pick the source; unassigned code and software mode route nothing
    always_comb begin
        req = 1'h0;
        if (hw_mode && sel != drs_pkg::SEL_UNASSIGNED) begin
            req = sources[sel];
        end
    end
endmodule

// ### drs_request_select.sv
// Request source selection for a four-channel DMA controller
`timescale 1ns/1ns
module drs_request_select (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Channel control words and trigger mode per channel
    input wire logic [31:0] channel_control_0,
    input wire logic [31:0] channel_control_1,
    input wire logic [31:0] channel_control_2,
    input wire logic [31:0] channel_control_3,
    input wire logic [3:0] hw_trigger_enable,
    // External request pins, active low, asynchronous
    input wire logic external_dma_request_0_n,
    input wire logic external_dma_request_1_n,
    // On-chip peripheral requests, same clock
    input wire logic [2:0] serial_port_request,
    input wire logic card_interface_request,
    input wire logic timer_request,
    input wire logic [3:0] usb_endpoint_request,
    input wire logic audio_serial_out_request,
    input wire logic audio_serial_in_request,
    input wire logic [1:0] spi_request,
    input wire logic pcm_input_request,
    input wire logic pcm_output_request,
    input wire logic microphone_input_request,
    // Routed requests and selector validity
    output logic [3:0] channel_request,
    output logic [3:0] source_assigned
);
    logic [1:0] ext_meta_reg;
    logic [1:0] ext_sync_reg;
    logic ext0;
    logic ext1;
    logic [2:0] sel [4];
    logic [6:0] src [4];
    logic [3:0] req_next;
    logic [3:0] channel_request_reg;
    logic [3:0] source_assigned_reg;

    // Selector field of a control word
    function automatic logic [2:0] sel_field(input logic [31:0] ctrl);
        sel_field = ctrl[drs_pkg::SEL_MSB:drs_pkg::SEL_LSB];
    endfunction

    // Two-stage synchroniser for the external pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_meta_reg <= {2{drs_pkg::SYNC_RESET_LEVEL}};
            ext_sync_reg <= {2{drs_pkg::SYNC_RESET_LEVEL}};
        end else if (ce) begin
            ext_meta_reg <= {external_dma_request_1_n, external_dma_request_0_n};
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // Pins are active low
    assign ext0 = ~ext_sync_reg[0];
    assign ext1 = ~ext_sync_reg[1];

    // Selector decode per channel
    assign sel[0] = sel_field(channel_control_0);
    assign sel[1] = sel_field(channel_control_1);
    assign sel[2] = sel_field(channel_control_2);
    assign sel[3] = sel_field(channel_control_3);

    // Source tables, bit index equals selector value
    assign src[0] = {pcm_input_request, audio_serial_out_request, usb_endpoint_request[0],
                     timer_request, card_interface_request, serial_port_request[0],
                     ext0};
    assign src[1] = {card_interface_request, pcm_output_request, usb_endpoint_request[1],
                     spi_request[0], audio_serial_in_request, serial_port_request[1],
                     ext1};
    assign src[2] = {microphone_input_request, pcm_input_request, usb_endpoint_request[2],
                     timer_request, card_interface_request, audio_serial_in_request,
                     audio_serial_out_request};
    assign src[3] = {pcm_output_request, microphone_input_request, usb_endpoint_request[3],
                     timer_request, spi_request[1], card_interface_request,
                     serial_port_request[2]};

    // One multiplexer per channel
    genvar g;
    generate
        for (g = 0; g < drs_pkg::NUM_CHANNELS; g++) begin : g_ch
            drs_source_mux u_mux (
                .sel(sel[g]),
                .hw_mode(hw_trigger_enable[g]),
                .sources(src[g]),
                .req(req_next[g])
            );
        end
    endgenerate

    // Registered routed requests
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_request_reg <= {4{drs_pkg::REQ_RESET_VALUE}};
        end else if (ce) begin
            channel_request_reg <= req_next;
        end
    end

    // Registered selector validity flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            source_assigned_reg <= {4{drs_pkg::ASSIGNED_RESET_VALUE}};
        end else if (ce) begin
            for (int i = 0; i < drs_pkg::NUM_CHANNELS; i++) begin
                source_assigned_reg[i] <= (sel[i] != drs_pkg::SEL_UNASSIGNED);
            end
        end
    end

    assign channel_request = channel_request_reg;
    assign source_assigned = source_assigned_reg;

    // Checks on routing
    field_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[3] && channel_control_3[26:24] == 3'h4
        |=> channel_request[3] == $past(usb_endpoint_request[3]))
        else $error("ch3 selector field not taken from bits 26:24");
    ch0_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[0] && sel[0] == 3'h0
        |=> channel_request[0] == $past(~ext_sync_reg[0]))
        else $error("ch0 code 0 not routed to ext pin 0");
    ch0_pcm_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[0] && sel[0] == 3'h6
        |=> channel_request[0] == $past(pcm_input_request))
        else $error("ch0 code 6 not routed to pcm input");
    ch1_card_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[1] && sel[1] == 3'h6
        |=> channel_request[1] == $past(card_interface_request))
        else $error("ch1 code 6 not routed to card interface");
    ch1_spi_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[1] && sel[1] == 3'h3
        |=> channel_request[1] == $past(spi_request[0]))
        else $error("ch1 code 3 not routed to spi 0");
    ch2_mic_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[2] && sel[2] == 3'h6
        |=> channel_request[2] == $past(microphone_input_request))
        else $error("ch2 code 6 not routed to microphone");
    ch2_audio_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[2] && sel[2] == 3'h0
        |=> channel_request[2] == $past(audio_serial_out_request))
        else $error("ch2 code 0 not routed to audio out");
    ch3_spi_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[3] && sel[3] == 3'h2
        |=> channel_request[3] == $past(spi_request[1]))
        else $error("ch3 code 2 not routed to spi 1");
    ch3_serial_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[3] && sel[3] == 3'h0
        |=> channel_request[3] == $past(serial_port_request[2]))
        else $error("ch3 code 0 not routed to serial 2");
    ch0_serial_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[0] && sel[0] == 3'h1
        |=> channel_request[0] == $past(serial_port_request[0]))
        else $error("ch0 code 1 not routed to serial 0");
    ch0_card_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[0] && sel[0] == 3'h2
        |=> channel_request[0] == $past(card_interface_request))
        else $error("ch0 code 2 not routed to card interface");
    ch0_timer_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[0] && sel[0] == 3'h3
        |=> channel_request[0] == $past(timer_request))
        else $error("ch0 code 3 not routed to timer");
    ch0_usb_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[0] && sel[0] == 3'h4
        |=> channel_request[0] == $past(usb_endpoint_request[0]))
        else $error("ch0 code 4 not routed to usb endpoint 1");
    ch0_audio_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[0] && sel[0] == 3'h5
        |=> channel_request[0] == $past(audio_serial_out_request))
        else $error("ch0 code 5 not routed to audio out");
    ch1_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[1] && sel[1] == 3'h0
        |=> channel_request[1] == $past(~ext_sync_reg[1]))
        else $error("ch1 code 0 not routed to ext pin 1");
    ch1_serial_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[1] && sel[1] == 3'h1
        |=> channel_request[1] == $past(serial_port_request[1]))
        else $error("ch1 code 1 not routed to serial 1");
    ch1_audio_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[1] && sel[1] == 3'h2
        |=> channel_request[1] == $past(audio_serial_in_request))
        else $error("ch1 code 2 not routed to audio in");
    ch1_usb_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[1] && sel[1] == 3'h4
        |=> channel_request[1] == $past(usb_endpoint_request[1]))
        else $error("ch1 code 4 not routed to usb endpoint 2");
    ch1_pcm_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[1] && sel[1] == 3'h5
        |=> channel_request[1] == $past(pcm_output_request))
        else $error("ch1 code 5 not routed to pcm output");
    ch2_audio_in_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[2] && sel[2] == 3'h1
        |=> channel_request[2] == $past(audio_serial_in_request))
        else $error("ch2 code 1 not routed to audio in");
    ch2_card_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[2] && sel[2] == 3'h2
        |=> channel_request[2] == $past(card_interface_request))
        else $error("ch2 code 2 not routed to card interface");
    ch2_timer_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[2] && sel[2] == 3'h3
        |=> channel_request[2] == $past(timer_request))
        else $error("ch2 code 3 not routed to timer");
    ch2_usb_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[2] && sel[2] == 3'h4
        |=> channel_request[2] == $past(usb_endpoint_request[2]))
        else $error("ch2 code 4 not routed to usb endpoint 3");
    ch2_pcm_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[2] && sel[2] == 3'h5
        |=> channel_request[2] == $past(pcm_input_request))
        else $error("ch2 code 5 not routed to pcm input");
    ch3_card_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[3] && sel[3] == 3'h1
        |=> channel_request[3] == $past(card_interface_request))
        else $error("ch3 code 1 not routed to card interface");
    ch3_timer_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[3] && sel[3] == 3'h3
        |=> channel_request[3] == $past(timer_request))
        else $error("ch3 code 3 not routed to timer");
    ch3_mic_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[3] && sel[3] == 3'h5
        |=> channel_request[3] == $past(microphone_input_request))
        else $error("ch3 code 5 not routed to microphone");
    ch3_pcm_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && hw_trigger_enable[3] && sel[3] == 3'h6
        |=> channel_request[3] == $past(pcm_output_request))
        else $error("ch3 code 6 not routed to pcm output");
    assigned_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce |=> source_assigned[2] == ($past(channel_control_2[26:24]) != 3'h7))
        else $error("ch2 validity flag does not follow the selector");
    unassigned_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && (sel[0] == 3'h7 || !hw_trigger_enable[0]) |=> !channel_request[0])
        else $error("ch0 request routed while unassigned or in software mode");
    frozen_ce_a: assert property (@(posedge clk) disable iff (!reset_n)
        !ce |=> $stable(channel_request) && $stable(source_assigned))
        else $error("outputs changed while clock enable low");
endmodule

// ### drs_req_model.sv
// Behavioural model of the requesters that stand beside the source select block
`timescale 1ns/1ns
module drs_req_model (
    // Request pattern from the bench, one bit per requester line
    input wire logic [17:0] lines,
    // External request pins, active low
    output logic external_dma_request_0_n,
    output logic external_dma_request_1_n,
    // On-chip peripheral requests, active high
    output logic [2:0] serial_port_request,
    output logic card_interface_request,
    output logic timer_request,
    output logic [3:0] usb_endpoint_request,
    output logic audio_serial_out_request,
    output logic audio_serial_in_request,
    output logic [1:0] spi_request,
    output logic pcm_input_request,
    output logic pcm_output_request,
    output logic microphone_input_request
);
    // Peripheral lines, bit 2 upward of the pattern
    assign {microphone_input_request, pcm_output_request, pcm_input_request, spi_request,
        audio_serial_in_request, audio_serial_out_request, usb_endpoint_request,
        timer_request, card_interface_request, serial_port_request} = lines[17:2];
    // Pins pull low when requesting
    assign {external_dma_request_1_n, external_dma_request_0_n} = ~lines[1:0];
endmodule

// ### drs_request_select_tb.sv
// Self-checking bench for the DMA request source select block
`timescale 1ns/1ns
module drs_request_select_tb;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic ce = 1'h1;
    logic [31:0] ctl [4] = '{default: 32'h0700_0000};
    logic [3:0] hw_trigger_enable = 4'hf;
    logic [17:0] lines = 18'h0;
    logic external_dma_request_0_n, external_dma_request_1_n, card_interface_request;
    logic timer_request, audio_serial_out_request, audio_serial_in_request;
    logic pcm_input_request, pcm_output_request, microphone_input_request;
    logic [2:0] serial_port_request;
    logic [3:0] usb_endpoint_request;
    logic [1:0] spi_request;
    logic [3:0] channel_request, source_assigned;
    int fail_count = 0;
    int num_checks = 0;
    // Pattern bit of each channel's source for selector 0..6
    int map [4][7] = '{'{0, 2, 5, 6, 7, 11, 15}, '{1, 3, 12, 13, 8, 16, 5},
        '{11, 12, 5, 6, 9, 15, 17}, '{4, 5, 14, 6, 10, 17, 16}};

    drs_req_model model (.lines, .external_dma_request_0_n, .external_dma_request_1_n,
        .serial_port_request, .card_interface_request, .timer_request, .usb_endpoint_request,
        .audio_serial_out_request, .audio_serial_in_request, .spi_request,
        .pcm_input_request, .pcm_output_request, .microphone_input_request);

    drs_request_select dut (.clk, .reset_n, .ce, .channel_control_0(ctl[0]),
        .channel_control_1(ctl[1]), .channel_control_2(ctl[2]), .channel_control_3(ctl[3]),
        .hw_trigger_enable, .external_dma_request_0_n, .external_dma_request_1_n,
        .serial_port_request, .card_interface_request, .timer_request, .usb_endpoint_request,
        .audio_serial_out_request, .audio_serial_in_request, .spi_request,
        .pcm_input_request, .pcm_output_request, .microphone_input_request,
        .channel_request, .source_assigned);

    // Free-running clock, 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Every channel, codes 0 to 6: lone source passes, all others blocked
    task automatic route_all;
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 7; s++) begin
                ctl[c] = 32'hf8ff_ffff | (32'(s) << 24);
                lines = 18'h1 << map[c][s];
                tick(4);
                check(channel_request, 4'(1 << c));
                check(source_assigned, 4'(1 << c));
                lines = ~(18'h1 << map[c][s]);
                tick(4);
                check(channel_request, 4'h0);
            end
            ctl[c] = 32'h0700_0000;
        end
    endtask

    // Code 7 and software-trigger channels see nothing
    task automatic mode_and_unassigned;
        lines = 18'h3ffff;
        tick(4);
        check(channel_request, 4'h0);
        check(source_assigned, 4'h0);
        ctl = '{default: 32'h0500_0000};
        hw_trigger_enable = 4'ha;
        tick(4);
        check(channel_request, 4'ha);
        check(source_assigned, 4'hf);
        hw_trigger_enable = 4'hf;
    endtask

    // One-cycle on-chip path, freeze with ce low, three-cycle pin path
    task automatic timing_and_freeze;
        lines = 18'h0;
        tick(4);
        lines[11] = 1'h1;
        tick(1);
        check(channel_request, 4'h1);
        ce = 1'h0;
        lines[11] = 1'h0;
        tick(3);
        check(channel_request, 4'h1);
        ce = 1'h1;
        tick(1);
        check(channel_request, 4'h0);
        ctl[0] = 32'h0;
        lines[0] = 1'h1;
        tick(2);
        check(channel_request, 4'h0);
        tick(1);
        check(channel_request, 4'h1);
    endtask

    // Reset in mid-run clears both outputs and restarts the pin synchroniser
    task automatic reset_mid_run;
        ctl = '{default: 32'h0700_0000};
        ctl[0] = 32'h0;
        lines = 18'h3ffff;
        tick(4);
        check(channel_request, 4'h1);
        reset_n = 1'h0;
        tick(2);
        check(channel_request, 4'h0);
        check(source_assigned, 4'h0);
        reset_n = 1'h1;
        tick(2);
        check(channel_request, 4'h0);
        tick(1);
        check(channel_request, 4'h1);
        check(source_assigned, 4'h1);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Reset for 20 cycles, then the scenarios
    initial begin
        tick(20);
        reset_n = 1'h1;
        tick(2);
        route_all();
        mode_and_unassigned();
        timing_and_freeze();
        reset_mid_run();
        report_and_stop();
    end
endmodule
